// File: rbl_consts.vh
// Constants for the rebuild assist log controller
// Assumes inclusion by rbl_log_ctrl.v only
`ifndef RBL_CONSTS_VH
`define RBL_CONSTS_VH
`define RBL_LOG_ADDR 8'h15
`define RBL_HDR_ENABLE_BYTE 9'h000
`define RBL_ENABLE_BIT 0
`define RBL_LEN_BYTE 9'h007
`define RBL_MASK_BASE 9'h008
`define RBL_ELEM_BYTES 8'h02
`define RBL_ELEMS 16
`define RBL_ELEM_W 4
`define RBL_MASK_RESET 16'hffff
`define RBL_SENSE_ABORTED 4'hb
`define RBL_ASC_MULTI_READ 16'h1103
`define RBL_TEST_CYCLES 8'h20
`endif

// File: rbl_log_ctrl.v
// Rebuild assist log and predicted-error logic
// Assumes a command layer on mclk presenting log bytes and queued reads
//
// Function
// - Log 15h exists when feature supported
// - Byte0 bit0 enable, byte7 length N
// - Mask from byte 8, bitmap from 8+N
// - Host writes to length, mask ignored
// - Mask marks implemented bitmap bits
// - Disabled element gives predicted errors
// - Enabled element gives no predicted errors
// - Enabling write starts element self-test
// - Bitmap loaded from self-test result
// - Background activity minimised while enabled
// - Log read returns enable as one
// - Clean queued read completes good
// - Report predicted and unpredicted errors
// - Read-continue flag bypasses feature
// - Power cycle clears enable
// - Write with enable zero disables feature, except during self-test, when log writes are ignored
// - Predicted read error logs sense 0Bh/1103h, LBAs
`timescale 1ns/1ps
`include "rbl_consts.vh"

module rbl_log_ctrl (
   // Clock and reset
   input wire mclk,
   input wire rstn,
   // Feature support and self-test result from drive
   input wire feature_supported,
   input wire [15:0] selftest_fail,
   // Log access: byte offset, write strobe, write data
   input wire log_sel,
   input wire [7:0] log_addr,
   input wire [8:0] log_byte,
   input wire log_wr,
   input wire log_rd,
   input wire [7:0] log_wdata,
   output reg [7:0] log_rdata_r,
   output reg log_rvalid_r,
   output reg log_err_r,
   // Queued read request
   input wire qrd_valid,
   input wire [47:0] qrd_lba,
   input wire [15:0] qrd_count,
   input wire rebuild_read_continue_flag,
   input wire qrd_unpred_err,
   // Queued read completion and error report
   output reg qrd_done_r,
   output reg qrd_good_r,
   output reg qrd_pred_err_r,
   output reg qrd_unpred_err_r,
   output reg [3:0] sense_key_r,
   output reg [15:0] sense_asc_r,
   output reg [47:0] err_lba_r,
   output reg [47:0] err_final_lba_r,
   // Write check: element of a write command
   input wire wr_chk_valid,
   input wire [47:0] wr_chk_lba,
   output reg wr_pred_err_r,
   output reg wr_chk_done_r,
   // Status
   output reg feature_en_r,
   output reg selftest_busy_r,
   output reg bg_inhibit_r,
   output reg [15:0] disabled_map_r
);

   localparam ST_IDLE = 2'b00;
   localparam ST_TEST = 2'b01;

   reg [1:0] state_r;
   reg [7:0] tcnt_r;
   reg [15:0] map_r;
   reg en_r;
   reg sup_s1_r;
   reg sup_r;

   // Log byte kinds
   localparam BK_RSVD = 3'b000;
   localparam BK_EN = 3'b001;
   localparam BK_LEN = 3'b010;
   localparam BK_MASK_HI = 3'b011;
   localparam BK_MASK_LO = 3'b100;
   localparam BK_MAP_HI = 3'b101;
   localparam BK_MAP_LO = 3'b110;

   wire test_on = (state_r == ST_TEST);

   ////////////////////////////////////////////////////////////////////
   // Decode functions

   // Element of an LBA: low bits select element
   function [`RBL_ELEM_W-1:0] elem_of;
      input [47:0] lba;
      begin
         elem_of = lba[`RBL_ELEM_W-1:0];
      end
   endfunction

   // Disabled check with mask gating
   function is_disabled;
      input [47:0] lba;
      input [15:0] map;
      reg [15:0] m;
      begin
         m = `RBL_MASK_RESET;
         is_disabled = map[elem_of(lba)] & m[elem_of(lba)];
      end
   endfunction

   // Kind of a log byte offset, shared by read and write paths
   function [2:0] byte_kind;
      input [8:0] b;
      reg [8:0] mb;
      begin
         mb = `RBL_MASK_BASE + {1'b0, `RBL_ELEM_BYTES};
         byte_kind = BK_RSVD;
         if (b == `RBL_HDR_ENABLE_BYTE)
            byte_kind = BK_EN;
         else if (b == `RBL_LEN_BYTE)
            byte_kind = BK_LEN;
         else if (b == `RBL_MASK_BASE)
            byte_kind = BK_MASK_HI;
         else if (b == `RBL_MASK_BASE + 9'h001)
            byte_kind = BK_MASK_LO;
         else if (b == mb)
            byte_kind = BK_MAP_HI;
         else if (b == mb + 9'h001)
            byte_kind = BK_MAP_LO;
      end
   endfunction

   // Contiguous disabled elements from the first block, bounded by count
   function [4:0] pred_run;
      input [47:0] lba;
      input [15:0] map;
      input [15:0] cnt;
      integer i;
      reg go;
      reg [`RBL_ELEM_W-1:0] e;
      reg [15:0] m;
      begin
         pred_run = 5'h00;
         go = 1'b1;
         m = `RBL_MASK_RESET;
         for (i = 0; i < `RBL_ELEMS; i = i + 1) begin
            e = elem_of(lba) + i[`RBL_ELEM_W-1:0];
            if (go && (i == 0 || i < cnt) && map[e] && m[e])
               pred_run = pred_run + 5'h01;
            else
               go = 1'b0;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Support strap synchroniser
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sup_s1_r <= 1'b0;
         sup_r <= 1'b0;
      end else begin
         sup_s1_r <= feature_supported;
         sup_r <= sup_s1_r;
      end
   end

   wire log_hit = log_sel && (log_addr == `RBL_LOG_ADDR);
   wire log_ok = log_hit && sup_r;
   wire [15:0] mask_w = `RBL_MASK_RESET;

   ////////////////////////////////////////////////////////////////////
   // Log read
   reg [7:0] rd_nxt;
   always @* begin
      rd_nxt = 8'h00;
      case (byte_kind(log_byte))
         BK_EN: begin
            rd_nxt = {7'h00, en_r};
         end
         BK_LEN: begin
            rd_nxt = `RBL_ELEM_BYTES;
         end
         BK_MASK_HI: begin
            rd_nxt = mask_w[15:8];
         end
         BK_MASK_LO: begin
            rd_nxt = mask_w[7:0];
         end
         BK_MAP_HI: begin
            rd_nxt = map_r[15:8];
         end
         BK_MAP_LO: begin
            rd_nxt = map_r[7:0];
         end
         default: begin
            rd_nxt = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Enable, self-test and bitmap
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         en_r <= 1'b0;
         state_r <= ST_IDLE;
         tcnt_r <= 8'h00;
         map_r <= 16'h0000;
         log_rdata_r <= 8'h00;
         log_rvalid_r <= 1'b0;
         log_err_r <= 1'b0;
      end else begin
         log_rvalid_r <= 1'b0;
         log_err_r <= 1'b0;
         if (log_sel && (log_rd || log_wr) && !log_ok)
            log_err_r <= 1'b1;
         if (log_ok && log_rd) begin
            log_rdata_r <= rd_nxt;
            log_rvalid_r <= 1'b1;
         end
         case (state_r)
            ST_IDLE: begin
               if (log_ok && log_wr) begin
                  case (byte_kind(log_byte))
                     BK_EN: begin
                        if (log_wdata[`RBL_ENABLE_BIT]) begin
                           state_r <= ST_TEST;
                           tcnt_r <= `RBL_TEST_CYCLES;
                        end else begin
                           en_r <= 1'b0;
                           map_r <= 16'h0000;
                        end
                     end
                     BK_MAP_HI: begin
                        map_r[15:8] <= log_wdata;
                     end
                     BK_MAP_LO: begin
                        map_r[7:0] <= log_wdata;
                     end
                     // Length and mask bytes dropped
                     BK_LEN, BK_MASK_HI, BK_MASK_LO: begin
                        state_r <= ST_IDLE;
                     end
                     default: begin
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_TEST: begin
               if (tcnt_r == 8'h01) begin
                  map_r <= selftest_fail & `RBL_MASK_RESET;
                  en_r <= 1'b1;
                  state_r <= ST_IDLE;
               end
               tcnt_r <= tcnt_r - 8'h01;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Queued read and write checks

   // Length of the predicted run from the first block
   reg [4:0] run_nxt;
   always @* begin
      run_nxt = pred_run(qrd_lba, disabled_map_r, qrd_count);
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         qrd_done_r <= 1'b0;
         qrd_good_r <= 1'b0;
         qrd_pred_err_r <= 1'b0;
         qrd_unpred_err_r <= 1'b0;
         sense_key_r <= 4'h0;
         sense_asc_r <= 16'h0000;
         err_lba_r <= 48'h0;
         err_final_lba_r <= 48'h0;
         wr_pred_err_r <= 1'b0;
         wr_chk_done_r <= 1'b0;
      end else begin
         qrd_done_r <= qrd_valid;
         wr_chk_done_r <= wr_chk_valid;
         wr_pred_err_r <= wr_chk_valid && feature_en_r &&
                          is_disabled(wr_chk_lba, disabled_map_r);
         if (qrd_valid) begin
            // Enable and map as seen at the status ports
            if (feature_en_r && !rebuild_read_continue_flag &&
                is_disabled(qrd_lba, disabled_map_r)) begin
               qrd_good_r <= 1'b0;
               qrd_pred_err_r <= 1'b1;
               qrd_unpred_err_r <= 1'b0;
               sense_key_r <= `RBL_SENSE_ABORTED;
               sense_asc_r <= `RBL_ASC_MULTI_READ;
               err_lba_r <= qrd_lba;
               err_final_lba_r <= qrd_lba + {43'h0, run_nxt} - 48'h000000000001;
            end else if (qrd_unpred_err) begin
               qrd_good_r <= 1'b0;
               qrd_pred_err_r <= 1'b0;
               qrd_unpred_err_r <= 1'b1;
               err_lba_r <= qrd_lba;
               err_final_lba_r <= qrd_lba;
            end else begin
               qrd_good_r <= 1'b1;
               qrd_pred_err_r <= 1'b0;
               qrd_unpred_err_r <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status outputs
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         feature_en_r <= 1'b0;
         selftest_busy_r <= 1'b0;
         bg_inhibit_r <= 1'b0;
         disabled_map_r <= 16'h0000;
      end else begin
         feature_en_r <= en_r;
         selftest_busy_r <= test_on;
         bg_inhibit_r <= en_r || test_on;
         disabled_map_r <= map_r;
      end
   end

endmodule // rbl_log_ctrl

// File: rbl_log_ctrl_asserts.sv
// Checker for the rebuild assist log controller
// Assumes a bind onto rbl_log_ctrl with feature support held high
`timescale 1ns/1ps
module rbl_log_ctrl_asserts (
   input wire mclk, rstn, log_sel, log_rd, log_wr, log_err_r, log_rvalid_r,
   input wire [7:0] log_addr, log_wdata,
   input wire [8:0] log_byte,
   input wire qrd_valid, rebuild_read_continue_flag, qrd_unpred_err,
   input wire qrd_good_r, qrd_pred_err_r, qrd_unpred_err_r, wr_chk_valid, wr_pred_err_r,
   input wire feature_en_r, selftest_busy_r,
   input wire [47:0] qrd_lba, err_lba_r, wr_chk_lba,
   input wire [3:0] sense_key_r,
   input wire [15:0] sense_asc_r, disabled_map_r
);
default clocking @(posedge mclk); endclocking
default disable iff (!rstn);
wire hit = log_sel && log_addr == 8'h15;
wire qpred = feature_en_r && !rebuild_read_continue_flag && disabled_map_r[qrd_lba[3:0]];
wire wpred = feature_en_r && disabled_map_r[wr_chk_lba[3:0]];
////////////////////////////////////////////////////////////////////////////////
rd_answer_a: assert property (
   hit && log_rd |=> log_rvalid_r && !log_err_r) else $error("log read unanswered");
bad_addr_a: assert property (
   log_sel && (log_rd || log_wr) && !hit |=> log_err_r) else $error("bad address accepted");
pred_read_a: assert property (
   qrd_valid && qpred |=> qrd_pred_err_r && sense_key_r == 4'hb && sense_asc_r == 16'h1103
   && err_lba_r == $past(qrd_lba)) else $error("predicted read report wrong");
cont_read_a: assert property (
   qrd_valid && rebuild_read_continue_flag && !qrd_unpred_err |=> qrd_good_r && !qrd_pred_err_r)
   else $error("continue read not good");
unpred_read_a: assert property (
   qrd_valid && !qpred && qrd_unpred_err |=> qrd_unpred_err_r && !qrd_good_r)
   else $error("unpredicted error lost");
wr_pred_a: assert property (
   wr_chk_valid |=> wr_pred_err_r == $past(wpred)) else $error("write check wrong");
test_len_a: assert property (
   $rose(selftest_busy_r) |=> selftest_busy_r [*8]) else $error("self-test too short");
off_write_a: assert property (
   hit && log_wr && log_byte == 9'h000 && !log_wdata[0] && !selftest_busy_r
   && !$past(hit && log_wr && log_byte == 9'h000 && log_wdata[0])
   |-> ##[1:3] !feature_en_r) else $error("feature not disabled");
cover property (qrd_valid && qpred);
cover property ($rose(feature_en_r));
cover property (log_err_r);
endmodule // rbl_log_ctrl_asserts
bind rbl_log_ctrl rbl_log_ctrl_asserts rbl_log_ctrl_asserts_i (.*);

// File: rbl_host.sv
// Host model issuing log accesses and queued reads; write check outputs held at zero
// Assumes the design samples its inputs on the rising edge of mclk
`timescale 1ns/1ps
module rbl_host (
   input wire mclk,
   input wire [7:0] log_rdata_r,
   input wire log_err_r,
   output reg log_sel, log_wr, log_rd, qrd_valid, rebuild_read_continue_flag,
   output reg qrd_unpred_err, wr_chk_valid,
   output reg [7:0] log_addr, log_wdata,
   output reg [8:0] log_byte,
   output reg [15:0] qrd_count,
   output reg [47:0] qrd_lba, wr_chk_lba
);
initial begin
   {log_sel, log_wr, log_rd, qrd_valid, rebuild_read_continue_flag, qrd_unpred_err} = 6'h00;
   {wr_chk_valid, log_addr, log_wdata, log_byte, qrd_count, qrd_lba, wr_chk_lba} = 138'h0;
end
////////////////////////////////////////////////////////////////////////////////
// One log access, answer taken one cycle on; data line inverted once released
task lg(input w, input [7:0] a, input [8:0] b, input [7:0] d, output [7:0] q, output e);
   begin
      @(negedge mclk);
      {log_sel, log_wr, log_rd, log_addr, log_byte, log_wdata} = {1'b1, w, !w, a, b, d};
      @(negedge mclk);
      q = log_rdata_r;
      e = log_err_r;
      {log_sel, log_wr, log_rd} = 3'h0;
      log_wdata = ~d;
   end
endtask
// Callers may issue queued reads in any LBA order
task qr(input [47:0] l, input f, input u);
   begin
      @(negedge mclk);
      {qrd_valid, qrd_lba, rebuild_read_continue_flag, qrd_unpred_err} = {1'b1, l, f, u};
      @(negedge mclk);
      qrd_valid = 1'b0;
      qrd_lba = ~l;
   end
endtask
endmodule // rbl_host

// File: rbl_log_ctrl_bench.sv
// Bench for the rebuild assist log controller
// Assumes rbl_host drives the log and queued-read inputs
`timescale 1ns/1ps
module rbl_log_ctrl_bench;
reg mclk = 1'b0;
reg rstn = 1'b0;
reg wr_chk_valid = 1'b0;
reg [47:0] wr_chk_lba = 48'h0;
reg [15:0] selftest_fail = 16'h0007;
wire feature_supported = 1'b1;
integer fail_count = 0;
integer num_checks = 0;
reg [7:0] q;
reg e;
wire log_sel, log_wr, log_rd, qrd_valid, rebuild_read_continue_flag, qrd_unpred_err;
wire log_rvalid_r, log_err_r, qrd_done_r, qrd_good_r, qrd_pred_err_r, qrd_unpred_err_r;
wire wr_pred_err_r, wr_chk_done_r, feature_en_r, selftest_busy_r, bg_inhibit_r;
wire [7:0] log_rdata_r, log_addr, log_wdata;
wire [8:0] log_byte;
wire [3:0] sense_key_r;
wire [15:0] qrd_count, sense_asc_r, disabled_map_r;
wire [47:0] qrd_lba, err_lba_r, err_final_lba_r;
rbl_log_ctrl rbl_log_ctrl_i (.*);
rbl_host rbl_host_i (.*, .wr_chk_valid(), .wr_chk_lba());
initial forever #25 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////////////
task chk(input string n, input [47:0] x, input [47:0] g);
   begin
      num_checks = num_checks + 1;
      if (g !== x) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0s exp %h got %h", n, x, g);
      end
   end
endtask
task rd(input [8:0] b, input [7:0] x);
   begin
      rbl_host_i.lg(1'b0, 8'h15, b, 8'h00, q, e);
      chk("log_rdata_r", x, q);
   end
endtask
task qc(input [47:0] l, input f, input u, input [2:0] x);
   begin
      rbl_host_i.qr(l, f, u);
      chk("qrd_status", x, {qrd_good_r, qrd_pred_err_r, qrd_unpred_err_r});
      chk("qrd_done_r", 1'b1, qrd_done_r);
   end
endtask
task give_verdict;
   begin
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
endtask
////////////////////////////////////////////////////////////////////////////////
task t_header;
   begin
      rd(9'h000, 8'h00);
      rbl_host_i.lg(1'b1, 8'h15, 9'h007, 8'h55, q, e);
      rbl_host_i.lg(1'b1, 8'h15, 9'h008, 8'h00, q, e);
      rbl_host_i.lg(1'b1, 8'h15, 9'h12c, 8'ha5, q, e);
      rd(9'h007, 8'h02);
      rd(9'h008, 8'hff);
      rd(9'h009, 8'hff);
      rd(9'h12c, 8'h00);
      rbl_host_i.lg(1'b0, 8'h16, 9'h000, 8'h00, q, e);
      chk("log_err_r", 1'b1, e);
   end
endtask
task t_enable;
   begin
      rbl_host_i.lg(1'b1, 8'h15, 9'h000, 8'h01, q, e);
      @(negedge mclk);
      chk("selftest_busy_r", 1'b1, selftest_busy_r);
      repeat (39) @(negedge mclk);
      rd(9'h000, 8'h01);
      rd(9'h00b, 8'h07);
      chk("feature_en_r", 1'b1, feature_en_r);
      chk("disabled_map_r", 16'h0007, disabled_map_r);
      chk("bg_inhibit_r", 1'b1, bg_inhibit_r);
   end
endtask
task t_reads;
   begin
      qc(48'h100, 1'b0, 1'b0, 3'b010);
      chk("sense", 20'hb1103, {sense_key_r, sense_asc_r});
      chk("err_final_lba_r", 48'h100, err_final_lba_r);
      chk("err_lba_r", 48'h100, err_lba_r);
      rbl_host_i.qrd_count = 16'h0004;
      qc(48'h100, 1'b0, 1'b0, 3'b010);
      chk("err_final_lba_r", 48'h102, err_final_lba_r);
      rbl_host_i.qrd_count = 16'h0000;
      qc(48'h103, 1'b0, 1'b0, 3'b100);
      qc(48'h102, 1'b1, 1'b0, 3'b100);
      qc(48'h104, 1'b0, 1'b1, 3'b001);
      @(negedge mclk);
      {wr_chk_valid, wr_chk_lba} = {1'b1, 48'h202};
      @(negedge mclk);
      wr_chk_valid = 1'b0;
      chk("wr_pred_err_r", 1'b1, wr_pred_err_r);
   end
endtask
task t_off;
   begin
      rbl_host_i.lg(1'b1, 8'h15, 9'h000, 8'h00, q, e);
      repeat (3) @(negedge mclk);
      qc(48'h300, 1'b0, 1'b0, 3'b100);
      rbl_host_i.lg(1'b1, 8'h15, 9'h000, 8'h01, q, e);
      repeat (40) @(negedge mclk);
      rstn = 1'b0;
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      repeat (3) @(negedge mclk);
      rd(9'h000, 8'h00);
   end
endtask
initial begin
   repeat (8) @(negedge mclk);
   rstn = 1'b1;
   repeat (3) @(negedge mclk);
   t_header;
   t_enable;
   t_reads;
   t_off;
   give_verdict;
end
initial begin
   #100000;
   fail_count = fail_count + 1;
   give_verdict;
end
endmodule // rbl_log_ctrl_bench
